/* File: hdl/cdcr_pkg.sv */
// Constants shared by the converter result and calibration register block
package cdcr_pkg;

  // Byte addresses reached through the serial register pointer
  localparam logic [7:0] ADDR_CH1_RESULT_HI = 8'h01;
  localparam logic [7:0] ADDR_CH1_RESULT_LO = 8'h02;
  localparam logic [7:0] ADDR_CH2_RESULT_HI = 8'h03;
  localparam logic [7:0] ADDR_CH2_RESULT_LO = 8'h04;
  localparam logic [7:0] ADDR_CH1_ZERO_HI   = 8'h05;
  localparam logic [7:0] ADDR_CH1_ZERO_LO   = 8'h06;
  localparam logic [7:0] ADDR_CH2_ZERO_HI   = 8'h07;
  localparam logic [7:0] ADDR_CH2_ZERO_LO   = 8'h08;
  localparam logic [7:0] ADDR_CH1_SPAN_HI   = 8'h09;
  localparam logic [7:0] ADDR_CH1_SPAN_LO   = 8'h0a;
  localparam logic [7:0] ADDR_CH1_SETUP     = 8'h0b;
  localparam logic [7:0] ADDR_CH2_SPAN_HI   = 8'h0c;
  localparam logic [7:0] ADDR_CH2_SPAN_LO   = 8'h0d;
  localparam logic [7:0] ADDR_CH2_SETUP     = 8'h0e;

  // Reset values
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] ZERO_RESET   = 16'h8000;
  localparam logic [7:0]  SETUP_RESET  = 8'h00;
  // Factory span default; arbitrary value, real parts are trimmed individually
  localparam logic [15:0] SPAN_FACTORY_DEFAULT = 16'h999a;

  // Setup register fields
  localparam int SETUP_RANGE_MSB = 7;
  localparam int SETUP_RANGE_LSB = 6;
  localparam int SETUP_DIFF_BIT  = 5;
  localparam logic [7:0] SETUP_USED_MASK = 8'he0;

  // Arithmetic constants
  localparam logic [15:0] DIFF_MIDSCALE = 16'h8000;
  localparam logic [15:0] SE_ZERO_CODE  = 16'h3000;
  localparam logic [15:0] RESULT_MAX    = 16'hfff0;
  localparam int          SPAN_SHIFT    = 16;

endpackage

/* File: hdl/cdcr_calc.sv */
// Offset and span correction of one raw conversion code
`timescale 1ns/1ps
`default_nettype none
module cdcr_calc
  import cdcr_pkg::*;
(
  // Raw code and coefficients
  input  wire logic [15:0] raw_code,
  input  wire logic [15:0] zero_coef,
  input  wire logic [15:0] span_coef,
  input  wire logic        differential,
  // Corrected result
  output logic      [15:0] result
);

  logic signed [18:0] delta;
  logic signed [17:0] factor;
  logic signed [36:0] product;
  logic signed [20:0] scaled;
  logic signed [21:0] biased;

  // Code minus (coefficient minus reference): mode picks the reference
  assign delta = $signed({3'b000, raw_code}) - $signed({3'b000, zero_coef})
               + $signed({3'b000, differential ? DIFF_MIDSCALE : SE_ZERO_CODE}); // R4 R5
  // Factor is (2^16 + span) / 2^16
  assign factor  = $signed({2'b01, span_coef}); // R6
  assign product = delta * factor; // R3
  assign scaled  = product[36:SPAN_SHIFT];
  // Midscale added back only for differential inputs
  assign biased  = $signed({scaled[20], scaled})
                 + $signed({6'b000000, differential ? DIFF_MIDSCALE : 16'h0000}); // R4 R5

  // Clamp and clear the unused low nibble
  assign result = (biased < 0) ? RESULT_RESET :
                  (biased > $signed({6'b000000, RESULT_MAX})) ? RESULT_MAX :
                  {biased[15:4], 4'h0}; // R21 R2

endmodule
`default_nettype wire

/* File: hdl/cdcr_regs.sv */
// Result, zero and span coefficient and setup registers of a two-channel converter
// How it works
// (R1) Each channel has a read-only 16-bit result at two byte addresses, reset zero.
// (R2) Only the upper twelve result bits carry data; low four read zero.
// (R3) Span correction maps raw 0x3000..0xCFF0 onto stored 0x0000..0xFFF0.
// (R4) Differential: (code - (zero - 0x8000)) times factor, plus 0x8000.
// (R5) Single-ended: (code - (zero - 0x3000)) times factor, no midscale.
// (R6) Factor equals (2^16 + span coefficient) divided by 2^16.
// (R7) A finished conversion loads that channel's result register.
// (R8) During a result read, that register holds and new results are lost.
// (R9) Bus stop ends the result read; updates resume afterwards.
// (R10) Host should read both result bytes in one auto-increment transfer.
// (R11) Each channel has a read/write 16-bit zero coefficient, reset 0x8000.
// (R12) Zero calibration stores the coefficient from the present input.
// (R13) Host-written zero coefficients are used exactly like calibrated ones.
// (R14) Host recalibrates or rewrites zero coefficient when changing input mode.
// (R15) Each channel uses its own zero and span coefficients.
// (R16) Each channel has a read/write span coefficient, factory preloaded.
// (R17) Setup byte: range in bits 7..6, differential in bit 5, rest zero.
// (R18) Range code selects the input range for the modulator.
// (R19) Pointer advances after every byte until the bus stop.
// (R20) Per-channel waiting flag reads low while unread new data is held.
// (R21) Computed result saturates to 0x0000..0xFFF0 with low nibble cleared.
`timescale 1ns/1ps
`default_nettype none
module cdcr_regs
  import cdcr_pkg::*;
#(
  parameter logic [15:0] CH1_SPAN_FACTORY = SPAN_FACTORY_DEFAULT,
  parameter logic [15:0] CH2_SPAN_FACTORY = SPAN_FACTORY_DEFAULT
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Conversion results from the modulator
  input  wire logic        conv_done,
  input  wire logic        conv_ch,
  input  wire logic [15:0] conv_code,
  // Zero calibration results from the modulator
  input  wire logic        zero_cal_done,
  input  wire logic        zero_cal_ch,
  input  wire logic [15:0] zero_cal_code,
  // Byte port from the serial protocol engine
  input  wire logic        ser_ptr_load,
  input  wire logic [7:0]  ser_ptr_value,
  input  wire logic        ser_wr,
  input  wire logic [7:0]  ser_wdata,
  input  wire logic        ser_rd,
  input  wire logic        ser_stop,
  output logic      [7:0]  ser_rdata,
  // Results and waiting flags
  output logic      [15:0] ch1_result,
  output logic      [15:0] ch2_result,
  output logic             ch1_result_waiting_n,
  output logic             ch2_result_waiting_n,
  // Input setup towards the modulator
  output logic      [1:0]  ch1_range,
  output logic             ch1_differential_select,
  output logic      [1:0]  ch2_range,
  output logic             ch2_differential_select
);

  logic [7:0]  ptr_reg;
  logic [7:0]  ptr_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic [15:0] result_reg [2];
  logic [15:0] result_next [2];
  logic [15:0] zero_reg [2];
  logic [15:0] zero_next [2];
  logic [15:0] span_reg [2];
  logic [15:0] span_next [2];
  logic [7:0]  setup_reg [2];
  logic [7:0]  setup_next [2];
  logic [1:0]  lock_reg;
  logic [1:0]  lock_next;
  logic [1:0]  waiting_n_reg;
  logic [1:0]  waiting_n_next;

  // Byte accessed this cycle, if any
  wire logic        access  = ser_rd | ser_wr;
  wire logic [15:0] calc_result;
  wire logic        conv_diff = setup_reg[conv_ch][SETUP_DIFF_BIT];

  // Read data for any pointer value; unmapped addresses read zero
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    case (a)
      ADDR_CH1_RESULT_HI: read_byte = result_reg[0][15:8];
      ADDR_CH1_RESULT_LO: read_byte = result_reg[0][7:0];
      ADDR_CH2_RESULT_HI: read_byte = result_reg[1][15:8];
      ADDR_CH2_RESULT_LO: read_byte = result_reg[1][7:0];
      ADDR_CH1_ZERO_HI:   read_byte = zero_reg[0][15:8];
      ADDR_CH1_ZERO_LO:   read_byte = zero_reg[0][7:0];
      ADDR_CH2_ZERO_HI:   read_byte = zero_reg[1][15:8];
      ADDR_CH2_ZERO_LO:   read_byte = zero_reg[1][7:0];
      ADDR_CH1_SPAN_HI:   read_byte = span_reg[0][15:8];
      ADDR_CH1_SPAN_LO:   read_byte = span_reg[0][7:0];
      ADDR_CH1_SETUP:     read_byte = setup_reg[0];
      ADDR_CH2_SPAN_HI:   read_byte = span_reg[1][15:8];
      ADDR_CH2_SPAN_LO:   read_byte = span_reg[1][7:0];
      ADDR_CH2_SETUP:     read_byte = setup_reg[1];
      default:            read_byte = 8'h00;
    endcase
  endfunction

  // Channel whose result bytes sit at an address
  function automatic logic [1:0] result_hit(input logic [7:0] a);
    result_hit[0] = (a == ADDR_CH1_RESULT_HI) || (a == ADDR_CH1_RESULT_LO);
    result_hit[1] = (a == ADDR_CH2_RESULT_HI) || (a == ADDR_CH2_RESULT_LO);
  endfunction

  wire logic [1:0] rd_result = ser_rd ? result_hit(ptr_reg) : 2'b00;

  // One corrector shared by both channels; each brings its own coefficients
  cdcr_calc u_calc (
    .raw_code     (conv_code),
    .zero_coef    (zero_reg[conv_ch]),  // R15
    .span_coef    (span_reg[conv_ch]),  // R15
    .differential (conv_diff),
    .result       (calc_result)
  );

  // Pointer advances after every byte until the next address phase
  assign ptr_next = ser_ptr_load ? ser_ptr_value :
                    access ? ptr_reg + 8'h01 : ptr_reg; // R19

  // Data sampled at the read strobe, so it stays put while it is shifted out.
  // A process, not an assign: the decode reads registers beyond its argument.
  always_comb begin
    rdata_next = ser_rd ? read_byte(ptr_reg) : rdata_reg;
  end

  // Strobes per channel, decoded once and shared by the next-value logic
  wire logic [1:0] conv_load;
  wire logic [1:0] cal_load;
  wire logic [1:0] wr_zero_hi;
  wire logic [1:0] wr_zero_lo;
  wire logic [1:0] wr_span_hi;
  wire logic [1:0] wr_span_lo;
  wire logic [1:0] wr_setup;

  // Replaces either byte of a word; bytes land one at a time, with no staging
  function automatic logic [15:0] merge_bytes(input logic [15:0] w, input logic hi,
                                              input logic lo, input logic [7:0] d);
    merge_bytes = {hi ? d : w[15:8], lo ? d : w[7:0]};
  endfunction

  for (genvar c = 0; c < 2; c++) begin : g_ch
    localparam logic       CH        = (c == 0) ? 1'b0 : 1'b1;
    localparam logic [7:0] ZERO_HI_A = (c == 0) ? ADDR_CH1_ZERO_HI : ADDR_CH2_ZERO_HI;
    localparam logic [7:0] ZERO_LO_A = (c == 0) ? ADDR_CH1_ZERO_LO : ADDR_CH2_ZERO_LO;
    localparam logic [7:0] SPAN_HI_A = (c == 0) ? ADDR_CH1_SPAN_HI : ADDR_CH2_SPAN_HI;
    localparam logic [7:0] SPAN_LO_A = (c == 0) ? ADDR_CH1_SPAN_LO : ADDR_CH2_SPAN_LO;
    localparam logic [7:0] SETUP_A   = (c == 0) ? ADDR_CH1_SETUP : ADDR_CH2_SETUP;

    // Conversions for a locked channel are dropped
    assign conv_load[c]  = conv_done && (conv_ch == CH) && !lock_reg[c]; // R7 R8
    assign cal_load[c]   = zero_cal_done && (zero_cal_ch == CH); // R12
    assign wr_zero_hi[c] = ser_wr && (ptr_reg == ZERO_HI_A); // R11 R13
    assign wr_zero_lo[c] = ser_wr && (ptr_reg == ZERO_LO_A); // R11 R13
    assign wr_span_hi[c] = ser_wr && (ptr_reg == SPAN_HI_A); // R16
    assign wr_span_lo[c] = ser_wr && (ptr_reg == SPAN_LO_A); // R16
    assign wr_setup[c]   = ser_wr && (ptr_reg == SETUP_A); // R17

    // Lock opens on a read of either of this channel's result bytes and closes at stop; a read wins
    assign lock_next[c] = rd_result[c] | (!ser_stop && lock_reg[c]); // R8 R9
    assign result_next[c] = conv_load[c] ? calc_result : result_reg[c]; // R1 R7
    // A stored result wins over the read that would mark it seen
    assign waiting_n_next[c] = conv_load[c] ? 1'b0 :
                               (rd_result[c] ? 1'b1 : waiting_n_reg[c]); // R20
    // Host bytes win over a calibration in the same cycle
    assign zero_next[c] = merge_bytes(cal_load[c] ? zero_cal_code : zero_reg[c],
                                      wr_zero_hi[c], wr_zero_lo[c], ser_wdata); // R12 R13
    assign span_next[c] = merge_bytes(span_reg[c], wr_span_hi[c], wr_span_lo[c],
                                      ser_wdata); // R16
    // Unused setup bits are not stored and read zero
    assign setup_next[c] = wr_setup[c] ? (ser_wdata & SETUP_USED_MASK) : setup_reg[c]; // R17
  end

  // Pointer and read data
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_reg   <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      ptr_reg   <= ptr_next;
      rdata_reg <= rdata_next;
    end
  end

  // Read locks and waiting flags
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_reg      <= 2'b00;
      waiting_n_reg <= 2'b11;
    end else begin
      lock_reg      <= lock_next;
      waiting_n_reg <= waiting_n_next;
    end
  end

  // Results
  always_ff @(posedge clk) begin
    if (rst) begin
      result_reg <= '{RESULT_RESET, RESULT_RESET}; // R1
    end else begin
      result_reg <= result_next;
    end
  end

  // Zero coefficients
  always_ff @(posedge clk) begin
    if (rst) begin
      zero_reg <= '{ZERO_RESET, ZERO_RESET}; // R11
    end else begin
      zero_reg <= zero_next;
    end
  end

  // Span coefficients; the reset value is the per-part factory trim
  always_ff @(posedge clk) begin
    if (rst) begin
      span_reg <= '{CH1_SPAN_FACTORY, CH2_SPAN_FACTORY}; // R16
    end else begin
      span_reg <= span_next;
    end
  end

  // Input setup
  always_ff @(posedge clk) begin
    if (rst) begin
      setup_reg <= '{SETUP_RESET, SETUP_RESET}; // R17
    end else begin
      setup_reg <= setup_next;
    end
  end

  // Outputs straight from flip-flops
  assign ser_rdata               = rdata_reg;
  assign ch1_result              = result_reg[0];
  assign ch2_result              = result_reg[1];
  assign ch1_result_waiting_n    = waiting_n_reg[0];
  assign ch2_result_waiting_n    = waiting_n_reg[1];
  assign ch1_range               = setup_reg[0][SETUP_RANGE_MSB:SETUP_RANGE_LSB]; // R18
  assign ch1_differential_select = setup_reg[0][SETUP_DIFF_BIT];
  assign ch2_range               = setup_reg[1][SETUP_RANGE_MSB:SETUP_RANGE_LSB]; // R18
  assign ch2_differential_select = setup_reg[1][SETUP_DIFF_BIT];

endmodule
`default_nettype wire

/* File: bench/cdcr_regs_checker.sv */
// Port-level assertions for the result and calibration register block
`timescale 1ns/1ps
`default_nettype none
module cdcr_regs_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Conversion and byte port inputs
  input wire logic        conv_done,
  input wire logic        conv_ch,
  input wire logic        ser_ptr_load,
  input wire logic [7:0]  ser_ptr_value,
  input wire logic        ser_wr,
  input wire logic [7:0]  ser_wdata,
  input wire logic        ser_rd,
  input wire logic        ser_stop,
  // Outputs under watch
  input wire logic [7:0]  ser_rdata,
  input wire logic [15:0] ch1_result,
  input wire logic [15:0] ch2_result,
  input wire logic        ch1_result_waiting_n,
  input wire logic        ch2_result_waiting_n,
  input wire logic [1:0]  ch1_range,
  input wire logic        ch1_differential_select
);
  logic [7:0] ptr;
  logic [1:0] lock;
  // Lock starts the cycle after a result byte read, so a same-edge conversion still lands
  wire logic [1:0] hit = {ser_rd && (ptr == 8'h03 || ptr == 8'h04),
                          ser_rd && (ptr == 8'h01 || ptr == 8'h02)};
  always_ff @(posedge clk) begin
    ptr  <= rst ? 8'h00 : ser_ptr_load ? ser_ptr_value : ptr + {7'h00, ser_rd | ser_wr};
    lock <= rst ? 2'h0 : hit | (ser_stop ? 2'h0 : lock);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd1; ser_rd && ptr == 8'h01; endsequence
  sequence s_free1; ser_stop && !hit[0] ##1 !ser_rd ##1 conv_done && !conv_ch; endsequence
  a_nibble_zero: assert property (ch1_result[3:0] == 4'h0 && ch2_result[3:0] == 4'h0)
    else $error("result low nibble set");
  a_conv_ch1: assert property (conv_done && !conv_ch && !lock[0] |=> !ch1_result_waiting_n)
    else $error("ch1 conversion not taken");
  a_conv_ch2: assert property (conv_done && conv_ch && !lock[1] |=> !ch2_result_waiting_n)
    else $error("ch2 conversion not taken");
  a_locked_holds: assert property (conv_done && !conv_ch && lock[0] |=> $stable(ch1_result))
    else $error("locked result changed");
  a_stop_frees: assert property (s_free1 |=> !ch1_result_waiting_n)
    else $error("result still locked after stop");
  a_read_clears: assert property
    (ser_rd && ptr == 8'h01 && !(conv_done && !conv_ch) |=> ch1_result_waiting_n)
    else $error("waiting flag not cleared by read");
  a_read_high: assert property (s_rd1 |=> ser_rdata == $past(ch1_result[15:8]))
    else $error("result high byte wrong");
  a_setup_fields: assert property (ser_wr && ptr == 8'h0b |=>
    ch1_range == $past(ser_wdata[7:6]) && ch1_differential_select == $past(ser_wdata[5]))
    else $error("setup fields wrong");
endmodule
bind cdcr_regs cdcr_regs_checker chk (.clk, .rst, .conv_done, .conv_ch, .ser_ptr_load,
  .ser_ptr_value, .ser_wr, .ser_wdata, .ser_rd, .ser_stop, .ser_rdata, .ch1_result,
  .ch2_result, .ch1_result_waiting_n, .ch2_result_waiting_n, .ch1_range,
  .ch1_differential_select);
`default_nettype wire

/* File: bench/cdcr_host.sv */
// Serial engine stand-in issuing byte port requests for the bus master
`timescale 1ns/1ps
`default_nettype none
module cdcr_host (
  // Clock
  input wire logic   clk,
  // Byte port towards the block
  output logic       ser_ptr_load,
  output logic [7:0] ser_ptr_value,
  output logic       ser_wr,
  output logic [7:0] ser_wdata,
  output logic       ser_rd,
  output logic       ser_stop
);
  initial begin
    {ser_ptr_load, ser_wr, ser_rd, ser_stop} = 4'h0;
    {ser_ptr_value, ser_wdata} = 16'h0000;
  end
  // Kind 0 pointer, 1 write, 2 read, 3 stop; one pulse per call
  task automatic op(input logic [1:0] k, input logic [7:0] d);
    @(posedge clk);
    {ser_stop, ser_rd, ser_wr, ser_ptr_load} <= 4'h1 << k;
    {ser_ptr_value, ser_wdata} <= {d, d};
    @(posedge clk);
    {ser_stop, ser_rd, ser_wr, ser_ptr_load} <= 4'h0;
    // Released data no longer shows the last byte
    {ser_ptr_value, ser_wdata} <= ~{d, d};
  endtask
endmodule
`default_nettype wire

/* File: bench/cdcr_regs_tb.sv */
// Queue-scored bench for the result and calibration register block
`timescale 1ns/1ps
`default_nettype none
module cdcr_regs_tb;
  logic        clk, rst, conv_done, conv_ch, zero_cal_done, zero_cal_ch, c;
  logic        ser_ptr_load, ser_wr, ser_rd, ser_stop, rd_seen, df [2], dsel [2];
  logic [15:0] conv_code, zero_cal_code, code, zr [2], sp [2], res [2], res_out [2];
  logic [1:0]  rng [2];
  logic [31:0] seed = 32'h20;
  logic [31:0] r;
  logic [7:0]  exp_q [$], ser_ptr_value, ser_wdata, ser_rdata;
  logic [1:0]  wait_n;
  int          bad_count, comparisons;
  cdcr_host host (.clk, .ser_ptr_load, .ser_ptr_value, .ser_wr, .ser_wdata, .ser_rd, .ser_stop);
  cdcr_regs #(.CH2_SPAN_FACTORY(16'h1234)) dut (.clk, .rst, .conv_done, .conv_ch, .conv_code,
    .zero_cal_done, .zero_cal_ch, .zero_cal_code, .ser_ptr_load, .ser_ptr_value, .ser_wr,
    .ser_wdata, .ser_rd, .ser_stop, .ser_rdata,
    .ch1_result(res_out[0]), .ch2_result(res_out[1]),
    .ch1_result_waiting_n(wait_n[0]), .ch2_result_waiting_n(wait_n[1]), .ch1_range(rng[0]),
    .ch1_differential_select(dsel[0]), .ch2_range(rng[1]), .ch2_differential_select(dsel[1]));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] calc(input logic [15:0] cd, z, s, input logic d);
    longint v;
    v = ((longint'(cd) - longint'(z) + (d ? 32768 : 12288)) * (65536 + longint'(s))) >>> 16;
    v = v + (d ? 32768 : 0);
    return v < 0 ? 16'h0000 : v > 65520 ? 16'hfff0 : v[15:0] & 16'hfff0;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Whole register in one transfer so both bytes belong to one conversion
  task automatic xfer(input logic [7:0] a, input logic [127:0] v, input int n, input logic rd);
    host.op(2'd0, a);
    for (int k = n - 1; k >= 0; k--) begin
      if (rd) exp_q.push_back(v[k*8 +: 8]);
      host.op(rd ? 2'd2 : 2'd1, v[k*8 +: 8]);
    end
    host.op(2'd3, 8'h00);
  endtask
  task automatic pulse(input logic cal, input logic ch, input logic [15:0] v);
    @(posedge clk);
    {conv_done, zero_cal_done, conv_ch, zero_cal_ch} <= {!cal, cal, ch, ch};
    {conv_code, zero_cal_code} <= {v, v};
    @(posedge clk);
    {conv_done, zero_cal_done} <= 2'b00;
    {conv_code, zero_cal_code} <= ~{v, v};
  endtask
  always @(posedge clk) rd_seen <= ser_rd;
  always @(negedge clk) if (rd_seen) check({8'h00, ser_rdata}, {8'h00, exp_q.pop_front()});
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    close_out();
  end
  initial begin
    {rst, conv_done, conv_ch, zero_cal_done, zero_cal_ch} = 5'h10;
    {conv_code, zero_cal_code} = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    xfer(8'h01, 128'h0000_0000_8000_8000_999a_0012_3400_0000, 16, 1'b1);
    check(wait_n, 2'b11);
    xfer(8'h01, 128'hffff, 2, 1'b0);
    xfer(8'h0f, 128'h55, 1, 1'b0);
    xfer(8'h01, 128'h0, 2, 1'b1);
    xfer(8'h0f, 128'h0, 1, 1'b1);
    for (int i = 0; i < 12; i++) begin
      c = i[0];
      r = rnd();
      df[c] = i[1];
      zr[c] = (i[1] ? 16'h8000 : 16'h3000) + {4'h0, r[11:0]} - 16'h0800;
      if (i[2]) pulse(1'b1, c, zr[c]);
      else xfer(c ? 8'h07 : 8'h05, {8'h00, zr[c]}, 2, 1'b0);
      sp[c] = r[31:16];
      xfer(c ? 8'h0c : 8'h09, {sp[c], r[15:14], df[c], 5'h1f}, 3, 1'b0);
      xfer(c ? 8'h0e : 8'h0b, {r[15:14], df[c], 5'h00}, 1, 1'b1);
      check({13'h0000, rng[c], dsel[c]}, {13'h0000, r[15:14], df[c]});
      r = rnd();
      code = r[15:0];
      res[c] = calc(code, zr[c], sp[c], df[c]);
      pulse(1'b0, c, code);
      @(negedge clk);
      check(wait_n[c], 1'b0);
      check(res_out[c], res[c]);
      xfer(c ? 8'h03 : 8'h01, res[c], 2, 1'b1);
      @(negedge clk);
      check(wait_n[c], 1'b1);
    end
    host.op(2'd0, 8'h01);
    exp_q.push_back(res[0][15:8]);
    host.op(2'd2, 8'h00);
    r = rnd();
    pulse(1'b0, 1'b0, r[15:0]);
    exp_q.push_back(res[0][7:0]);
    host.op(2'd2, 8'h00);
    host.op(2'd3, 8'h00);
    @(negedge clk);
    check(wait_n[0], 1'b1);
    check(res_out[0], res[0]);
    r = rnd();
    res[0] = calc(r[15:0], zr[0], sp[0], df[0]);
    pulse(1'b0, 1'b0, r[15:0]);
    xfer(8'h01, res[0], 2, 1'b1);
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule
`default_nettype wire
